//--- sphs_consts.svh
// constants for the serial hold, reset and status register front end
`ifndef SPHS_CONSTS_SVH
`define SPHS_CONSTS_SVH

`define SPHS_OP_RDSR1 8'h05
`define SPHS_OP_RDSR2 8'h35
`define SPHS_OP_RDSR3 8'h15
`define SPHS_OP_WRSR1 8'h01
`define SPHS_OP_WRSR2 8'h31
`define SPHS_OP_WRSR3 8'h11
`define SPHS_OP_RDIND 8'h65
`define SPHS_OP_WRIND 8'h71
`define SPHS_OP_WREN 8'h06
`define SPHS_OP_VWREN 8'h50
`define SPHS_OP_PDREL 8'hab
`define SPHS_NUM_SR 5
`define SPHS_ADDR_MIN 8'h01
`define SPHS_ADDR_MAX 8'h05
`define SPHS_QE_BIT 1
`define SPHS_RSTCFG_BIT 7
`define SPHS_PDREL_SHORT 3'h1
`define SPHS_PDREL_LONG 3'h5
`define SPHS_ID_BYTE 3'h3
`define SPHS_BYTE_MAX 3'h7
`define SPHS_CLK_MHZ 10
`define SPHS_T_NVWR_US 5000
`define SPHS_TMR_W 17
`define SPHS_NV_RESET 40'h0000000000
`define SPHS_SYNC_RESET 4'h9

`endif

//--- sphs_hold_status.sv
// serial flash front end: byte framing, hold or reset pin, status registers
`timescale 1ns/1ps
`include "sphs_consts.svh"
module sphs_hold_status
#(
    parameter int unsigned NV_WR_CYC = `SPHS_T_NVWR_US * `SPHS_CLK_MHZ,
    // identifier byte value is arbitrary
    parameter logic [7:0] DEV_ID = 8'h5a
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic csNIn,
    input wire logic sckIn,
    input wire logic siIn,
    output logic soOut,
    output logic soOeN,
    // shared hold, reset or fourth data pin
    input wire logic io3In,
    output logic io3Out,
    output logic io3OeN,
    // control and status
    input wire logic powerDownReq,
    output logic busy,
    output logic powerDown,
    output logic quadMode,
    output logic resetMode,
    output logic inHold,
    output logic inReset
);
    import sphs_pkg::*;

    // ************************************************************
    // pin synchroniser
    // ************************************************************

    sphs_pin_if pins();

    sphs_pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .csNIn(csNIn),
        .sckIn(sckIn),
        .siIn(siIn),
        .io3In(io3In),
        .pins(pins)
    );

    // ************************************************************
    // opcode decoding
    // ************************************************************

    function automatic logic [2:0] dirIdx(input logic [7:0] op);
        case (op)
            `SPHS_OP_RDSR1, `SPHS_OP_WRSR1: return 3'h1;
            `SPHS_OP_RDSR2, `SPHS_OP_WRSR2: return 3'h2;
            `SPHS_OP_RDSR3, `SPHS_OP_WRSR3: return 3'h3;
            default: return 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] indIdx(input logic [7:0] a);
        if (a >= `SPHS_ADDR_MIN && a <= `SPHS_ADDR_MAX)
        begin
            return a[2:0];
        end
        return 3'h0;
    endfunction

    function automatic logic isRd(input logic [7:0] op);
        return op == `SPHS_OP_RDSR1 || op == `SPHS_OP_RDSR2 || op == `SPHS_OP_RDSR3;
    endfunction

    function automatic logic isWr(input logic [7:0] op);
        return op == `SPHS_OP_WRSR1 || op == `SPHS_OP_WRSR2 || op == `SPHS_OP_WRSR3
            || op == `SPHS_OP_WRIND;
    endfunction

    // register one shows live busy and write-enable, not stored bits
    function automatic logic [7:0] srRead(input sphs_core_s s, input logic [2:0] i);
        logic [7:0] v;
        v = 8'h00;
        for (int k = 0; k < `SPHS_NUM_SR; k++)
        begin
            if (i == 3'(k + 1))
            begin
                v = s.sr[k];
            end
        end
        if (i == 3'h1)
        begin
            v = {s.sr[0][7:2], s.wel, s.busy};
        end
        return v;
    endfunction

    // ************************************************************
    // state
    // ************************************************************

    sphs_core_s r;
    sphs_core_s next_r;
    logic holdMode;
    logic devRst;
    logic [7:0] inByte;
    logic [7:0] wdata;
    logic [2:0] widx;
    logic [7:0] rdOp;
    logic [7:0] rdAddr;
    logic wrLong;
    logic wrOk;

    assign quadMode = r.sr[1][`SPHS_QE_BIT];
    assign resetMode = r.sr[2][`SPHS_RSTCFG_BIT] & ~quadMode;
    assign holdMode = ~r.sr[2][`SPHS_RSTCFG_BIT] & ~quadMode;
    assign devRst = resetMode & ~pins.holdN;

    // ************************************************************
    // next state
    // ************************************************************

    always_comb
    begin
        next_r = r;
        inByte = {r.shIn[6:0], pins.si};
        wrLong = r.op == `SPHS_OP_WRIND;
        wdata = wrLong ? r.dat : r.addr;
        widx = wrLong ? indIdx(r.addr) : dirIdx(r.op);
        wrOk = isWr(r.op) && widx != 3'h0 && (r.wel || r.vwel) && !r.busy
            && (wrLong ? r.byteCnt >= 3'h3 : r.byteCnt >= 3'h2);
        rdOp = (r.byteCnt == 3'h0) ? inByte : r.op;
        rdAddr = (r.byteCnt == 3'h1) ? inByte : r.addr;
        if (r.busy)
        begin
            if (r.tmr <= `SPHS_TMR_W'(1))
            begin
                next_r.busy = 1'b0;
                next_r.tmr = '0;
            end
            else
            begin
                next_r.tmr = r.tmr - `SPHS_TMR_W'(1);
            end
        end
        if (r.st == SPHS_LOAD)
        begin
            next_r.sr = r.nv;
            next_r.st = SPHS_IDLE;
        end
        else if (devRst)
        begin
            // stored copy untouched; the loss of volatile state is the point
            next_r.sr = r.nv;
            next_r.bitCnt = 3'h0;
            next_r.byteCnt = 3'h0;
            next_r.outEn = 1'b0;
            next_r.hold = 1'b0;
            next_r.wel = 1'b0;
            next_r.vwel = 1'b0;
            next_r.busy = 1'b0;
            next_r.tmr = '0;
        end
        else if (pins.csN)
        begin
            if (powerDownReq && !r.busy)
            begin
                next_r.pd = 1'b1;
            end
            if (pins.csRise && r.bitCnt == 3'h0)
            begin
                if (r.op == `SPHS_OP_PDREL)
                begin
                    if (r.byteCnt == `SPHS_PDREL_SHORT || r.byteCnt >= `SPHS_PDREL_LONG)
                    begin
                        next_r.pd = 1'b0;
                    end
                end
                else if (!r.pd && r.byteCnt != 3'h0)
                begin
                    if (r.op == `SPHS_OP_WREN && !r.busy)
                    begin
                        next_r.wel = 1'b1;
                    end
                    else if (r.op == `SPHS_OP_VWREN && !r.busy)
                    begin
                        next_r.vwel = 1'b1;
                    end
                    else if (wrOk)
                    begin
                        for (int k = 0; k < `SPHS_NUM_SR; k++)
                        begin
                            if (widx == 3'(k + 1))
                            begin
                                next_r.sr[k] = wdata;
                                if (k == 0)
                                begin
                                    next_r.sr[0][1:0] = 2'b00;
                                end
                                if (r.wel)
                                begin
                                    next_r.nv[k] = next_r.sr[k];
                                end
                            end
                        end
                        if (r.wel)
                        begin
                            next_r.busy = 1'b1;
                            next_r.tmr = NV_WR_CYC[`SPHS_TMR_W-1:0];
                        end
                        next_r.wel = 1'b0;
                        next_r.vwel = 1'b0;
                    end
                end
            end
            next_r.bitCnt = 3'h0;
            next_r.byteCnt = 3'h0;
            next_r.op = 8'h00;
            next_r.outEn = 1'b0;
            next_r.hold = 1'b0;
        end
        else
        begin
            // hold only changes on a falling clock edge
            if (pins.sckFall)
            begin
                if (!r.hold && holdMode && !pins.holdN)
                begin
                    next_r.hold = 1'b1;
                end
                else if (r.hold && pins.holdN)
                begin
                    next_r.hold = 1'b0;
                end
            end
            if (!holdMode)
            begin
                next_r.hold = 1'b0;
            end
            // the releasing fall does the shift that the pausing fall skipped
            if (!next_r.hold)
            begin
                if (pins.sckFall)
                begin
                    next_r.so = r.shOut[7];
                    next_r.shOut = {r.shOut[6:0], 1'b0};
                end
                if (pins.sckRise)
                begin
                    next_r.shIn = inByte;
                    next_r.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7)
                    begin
                        if (r.byteCnt != `SPHS_BYTE_MAX)
                        begin
                            next_r.byteCnt = r.byteCnt + 3'h1;
                        end
                        if (r.byteCnt == 3'h0)
                        begin
                            next_r.op = inByte;
                        end
                        if (r.byteCnt == 3'h1)
                        begin
                            next_r.addr = inByte;
                        end
                        if (r.byteCnt == 3'h2)
                        begin
                            next_r.dat = inByte;
                        end
                        // read data loads at byte end, first bit leaves on next fall
                        if (!r.pd && rdOp == `SPHS_OP_RDIND && r.byteCnt != 3'h0)
                        begin
                            next_r.shOut = srRead(r, indIdx(rdAddr));
                            next_r.outEn = 1'b1;
                        end
                        else if (!r.pd && isRd(rdOp))
                        begin
                            next_r.shOut = srRead(r, dirIdx(rdOp));
                            next_r.outEn = 1'b1;
                        end
                        else if (rdOp == `SPHS_OP_PDREL && r.byteCnt >= `SPHS_ID_BYTE)
                        begin
                            next_r.shOut = DEV_ID;
                            next_r.outEn = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= SPHS_LOAD;
            r.nv <= `SPHS_NV_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    assign soOut = r.so;
    assign soOeN = ~(r.outEn & ~r.hold & ~pins.csN & ~devRst);
    // quad transfers live elsewhere; this block never drives the shared pin
    assign io3Out = 1'b0;
    assign io3OeN = 1'b1;
    assign busy = r.busy;
    assign powerDown = r.pd;
    assign inHold = r.hold;
    assign inReset = devRst;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_oddEnd;
        pins.csRise && r.bitCnt != 3'h0 && !devRst |=> $stable(r.sr) && $stable(r.pd);
    endproperty
    a_oddEnd: assert property (p_oddEnd) else $error("odd select end changed state");

    property p_pdRelease;
        pins.csRise && r.bitCnt == 3'h0 && r.op == `SPHS_OP_PDREL && r.pd && !devRst
            && (r.byteCnt == 3'h1 || r.byteCnt >= 3'h5) |=> !r.pd;
    endproperty
    a_pdRelease: assert property (p_pdRelease) else $error("release not executed");

    property p_idOut;
        pins.sckRise && !pins.csN && !r.hold && !next_r.hold && !devRst && r.st == SPHS_IDLE
            && r.op == `SPHS_OP_PDREL && r.bitCnt == 3'h7 && r.byteCnt == 3'h3
            |=> r.shOut == DEV_ID && r.outEn;
    endproperty
    a_idOut: assert property (p_idOut) else $error("identifier not loaded");

    property p_holdMode;
        r.hold |-> !r.sr[2][`SPHS_RSTCFG_BIT] && !r.sr[1][`SPHS_QE_BIT];
    endproperty
    a_holdMode: assert property (p_holdMode) else $error("hold in wrong pin mode");

    property p_resetBlocks;
        devRst |=> r.bitCnt == 3'h0 && r.byteCnt == 3'h0 && r.sr == $past(r.nv);
    endproperty
    a_resetBlocks: assert property (p_resetBlocks) else $error("reset did not block");

    property p_holdEnter;
        !r.hold && holdMode && !pins.csN && !pins.holdN && pins.sckFall && !devRst
            && r.st == SPHS_IDLE |=> r.hold;
    endproperty
    a_holdEnter: assert property (p_holdEnter) else $error("hold missed falling edge");

    property p_holdFloat;
        r.hold |-> soOeN && $stable(r.bitCnt);
    endproperty
    a_holdFloat: assert property (p_holdFloat) else $error("activity during hold");

    property p_volWrite;
        pins.csRise && !devRst && r.st == SPHS_IDLE && wrOk && r.vwel && !r.wel && !r.pd
            && r.bitCnt == 3'h0
            |=> !r.busy && $stable(r.nv) && !r.vwel;
    endproperty
    a_volWrite: assert property (p_volWrite) else $error("volatile write was slow");

    property p_nvWrite;
        pins.csRise && !devRst && r.st == SPHS_IDLE && wrOk && r.wel && !r.pd
            && r.bitCnt == 3'h0
            |=> r.busy ##1 r.busy;
    endproperty
    a_nvWrite: assert property (p_nvWrite) else $error("stored write not timed");
endmodule

//--- sphs_hold_status_test.sv
// self-checking bench for the serial hold, reset and status register front end
`timescale 1ns/1ps
module sphs_hold_status_test;
    import sphs_pkg::*;
    // short stored write time keeps the run brief
    localparam int unsigned NV_CYC = 400;
    // identifier value is arbitrary
    localparam logic [7:0] ID_VAL = 8'hc3;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic powerDownReq = 1'b0;
    logic csN, sck, si, hostIo3, soOut, soOeN, io3Out, io3OeN;
    logic busy, powerDown, quadMode, resetMode, inHold, inReset;
    wire logic io3Wire;
    logic soLine;
    int holdCyc = 0;
    logic [7:0] expSr [5];
    int n_errors = 0;
    int samples_checked = 0;

    assign io3Wire = io3OeN ? hostIo3 : io3Out;
    // an undriven output line reads inverted, so a missing enable shows up as bad data
    assign soLine = soOeN ? ~soOut : soOut;

    always @(negedge sys_clk)
    begin
        if (inHold)
            holdCyc++;
    end
    always #50 sys_clk = ~sys_clk;

    sphs_hold_status #(.NV_WR_CYC(NV_CYC), .DEV_ID(ID_VAL)) uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .csNIn(csN), .sckIn(sck), .siIn(si),
        .soOut(soOut), .soOeN(soOeN), .io3In(io3Wire), .io3Out(io3Out), .io3OeN(io3OeN),
        .powerDownReq(powerDownReq), .busy(busy), .powerDown(powerDown),
        .quadMode(quadMode), .resetMode(resetMode), .inHold(inHold), .inReset(inReset)
    );

    sphs_host_model host
    (
        .sys_clk(sys_clk), .csN(csN), .sck(sck), .si(si), .io3(hostIo3),
        .soOut(soLine), .soOeN(soOeN)
    );

    // ************
    // shared helpers
    // ************
    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] tx[$], input logic [7:0] exp, input string what);
        tx.push_back(8'h00);
        host.frame(tx, 0, -1);
        chk(host.rxByte, exp, what);
    endtask

    task automatic vwr(input logic [7:0] tx[$]);
        host.frame('{8'h50}, 0, -1);
        host.frame(tx, 0, -1);
    endtask

    task automatic chkAll();
        for (int i = 1; i <= 5; i++)
            rdChk('{8'h65, 8'(i)}, expSr[i-1], "indirect read");
    endtask

    task automatic pdEnter();
        powerDownReq <= 1'b1;
        @(posedge sys_clk);
        powerDownReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // ************
    // scenarios
    // ************
    task automatic t_reset();
        chk({busy, powerDown, quadMode, resetMode, inHold, inReset, soOeN, io3OeN}, 8'h03,
            "flags after reset");
        chk(io3Out, 8'h00, "shared pin output level");
        expSr = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        chkAll();
    endtask

    task automatic t_access();
        vwr('{8'h01, 8'hfc});
        vwr('{8'h31, 8'h3c});
        vwr('{8'h11, 8'h55});
        chk(busy, 8'h00, "busy after volatile write");
        rdChk('{8'h05}, 8'hfc, "read one");
        rdChk('{8'h35}, 8'h3c, "read two");
        rdChk('{8'h15}, 8'h55, "read three");
        vwr('{8'h71, 8'h04, 8'ha5});
        vwr('{8'h71, 8'h05, 8'h5a, 8'hff});
        expSr = '{8'hfc, 8'h3c, 8'h55, 8'ha5, 8'h5a};
        chkAll();
        vwr('{8'h71, 8'h06, 8'h00});
        rdChk('{8'h65, 8'h06}, 8'h00, "outside address");
        rdChk('{8'h65, 8'h00}, 8'h00, "address zero");
        host.frame('{8'h50}, 0, -1);
        host.frame('{8'h01, 8'h00}, 1, -1);
        chkAll();
    endtask

    task automatic t_stored();
        int c;
        vwr('{8'h01, 8'hfc});
        host.frame('{8'h06}, 0, -1);
        host.frame('{8'h11, 8'hc0}, 0, -1);
        chk(busy, 8'h01, "busy after stored write");
        rdChk('{8'h05}, 8'hfd, "busy bit in status one");
        c = 0;
        while (busy !== 1'b0 && c < 1000)
        begin
            @(negedge sys_clk);
            c++;
        end
        chk(8'(c >= 240 && c <= 260), 8'h01, "stored write length");
        chk(resetMode, 8'h01, "reset role");
        expSr[2] = 8'hc0;
        chkAll();
    endtask

    task automatic t_pinReset();
        vwr('{8'h01, 8'h80});
        host.pin(1'b0);
        chk(inReset, 8'h01, "pin reset seen");
        host.frame('{8'h50}, 0, -1);
        host.pin(1'b1);
        host.frame('{8'h01, 8'h44}, 0, -1);
        expSr = '{8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};
        chkAll();
        vwr('{8'h11, 8'h00});
        chk(resetMode, 8'h00, "hold role");
        vwr('{8'h31, 8'h02});
        vwr('{8'h11, 8'h80});
        chk({quadMode, resetMode}, 8'h02, "quad overrides reset");
        host.pin(1'b0);
        rdChk('{8'h35}, 8'h02, "read with pin low in quad");
        chk({inHold, inReset}, 8'h00, "no hold in quad");
        host.pin(1'b1);
        vwr('{8'h31, 8'h00});
        chk(resetMode, 8'h01, "reset role back");
        vwr('{8'h11, 8'h00});
    endtask

    task automatic t_hold();
        int h0;
        host.frame('{8'h50}, 0, -1);
        host.frame('{8'h71, 8'h03, 8'h33}, 0, 0);
        host.holdLeak = 0;
        h0 = holdCyc;
        host.frame('{8'h65, 8'h03, 8'h00}, 0, 1);
        chk(host.rxByte, 8'h33, "read across hold");
        chk(8'(holdCyc - h0), 8'h1c, "hold length in cycles");
        chk(8'(host.holdLeak), 8'h00, "output driven in hold");
        expSr = '{8'h00, 8'h00, 8'h33, 8'h00, 8'h00};
        chkAll();
    endtask

    task automatic t_powerDown();
        pdEnter();
        chk(powerDown, 8'h01, "enter power-down");
        host.frame('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00}, 0, -1);
        chk(host.rxByte, ID_VAL, "identifier");
        chk(powerDown, 8'h00, "released after 40");
        pdEnter();
        for (int e = 1; e <= 2; e++)
        begin
            host.frame('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00}, e, -1);
            chk(host.rxByte, ID_VAL, "identifier odd end");
            chk(powerDown, 8'h01, "kept after odd end");
            host.frame('{8'hab}, e, -1);
            chk(powerDown, 8'h01, "kept after 9 or 10");
        end
        host.frame('{8'hab}, 0, -1);
        chk(powerDown, 8'h00, "released after 8");
    endtask

    // ************
    // sequence and watchdog
    // ************
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        t_reset();
        t_access();
        t_stored();
        t_pinReset();
        t_hold();
        t_powerDown();
        test_done();
    end

    // the whole run needs a little over a fifth of this span
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        test_done();
    end
endmodule

//--- sphs_host_model.sv
// host side serial controller model driving select, clock, data and the shared pin
`timescale 1ns/1ps
module sphs_host_model
(
    // clock
    input wire logic sys_clk,
    // pins towards the device
    output logic csN,
    output logic sck,
    output logic si,
    output logic io3,
    input wire logic soOut,
    input wire logic soOeN
);
    logic [7:0] shift;
    logic [7:0] rxByte;
    int holdLeak;

    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        io3 = 1'b1;
        shift = 8'h00;
        rxByte = 8'h00;
        holdLeak = 0;
    end

    task automatic waitClk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // ************
    // one clock of the link, mode 0, half period of four system clocks
    // ************
    // sampled at the next fall so the slow edge finder has surely updated the output
    task automatic clkBit(input logic b);
        sck <= 1'b0;
        si <= b;
        waitClk(4);
        sck <= 1'b1;
        waitClk(4);
        shift = {shift[6:0], soOut};
    endtask

    task automatic pin(input logic v);
        io3 <= v;
        waitClk(6);
    endtask

    // select stays low through the whole pause; clocks keep running for other agents
    task automatic holdGap();
        io3 <= 1'b0;
        waitClk(4);
        for (int g = 0; g < 3; g++)
        begin
            clkBit(g[0]);
            if (soOeN !== 1'b1)
                holdLeak++;
        end
        io3 <= 1'b1;
        waitClk(4);
    endtask

    task automatic frame(input logic [7:0] tx[$], input int extra, input int holdAfter);
        csN <= 1'b0;
        waitClk(4);
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
                clkBit(tx[i][k]);
            rxByte = shift;
            if (i == holdAfter)
                holdGap();
        end
        repeat (extra) clkBit(1'b0);
        sck <= 1'b0;
        waitClk(4);
        csN <= 1'b1;
        si <= ~si;
        waitClk(8);
    endtask
endmodule

//--- sphs_pin_if.sv
// synchronised pin levels and edge events between synchroniser and core
`timescale 1ns/1ps
interface sphs_pin_if;
    logic csN;
    logic si;
    logic holdN;
    logic sckRise;
    logic sckFall;
    logic csRise;
    modport drv (output csN, si, holdN, sckRise, sckFall, csRise);
    modport core (input csN, si, holdN, sckRise, sckFall, csRise);
endinterface

//--- sphs_pin_sync.sv
// two-flop synchroniser and edge finder for the serial pins
`timescale 1ns/1ps
`include "sphs_consts.svh"
module sphs_pin_sync
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // raw pins
    input wire logic csNIn,
    input wire logic sckIn,
    input wire logic siIn,
    input wire logic io3In,
    // synchronised side
    sphs_pin_if.drv pins
);
    import sphs_pkg::*;

    sphs_sync_s r;
    sphs_sync_s next_r;

    // select idles high and the shared pin idles high, so no false event at reset
    always_comb
    begin
        next_r.s1 = {io3In, siIn, sckIn, csNIn};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= {`SPHS_SYNC_RESET, `SPHS_SYNC_RESET, `SPHS_SYNC_RESET};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pins.csN = r.s2[0];
    assign pins.si = r.s2[2];
    assign pins.holdN = r.s2[3];
    assign pins.sckRise = r.s2[1] & ~r.s3[1];
    assign pins.sckFall = ~r.s2[1] & r.s3[1];
    assign pins.csRise = r.s2[0] & ~r.s3[0];
endmodule

//--- sphs_pkg.sv
// types shared by the serial hold and status register front end
package sphs_pkg;
`include "sphs_consts.svh"

    typedef enum logic {SPHS_LOAD, SPHS_IDLE} sphs_st_e;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } sphs_sync_s;

    typedef struct packed {
        sphs_st_e st;
        logic [7:0] shIn;
        logic [2:0] bitCnt;
        logic [2:0] byteCnt;
        logic [7:0] op;
        logic [7:0] addr;
        logic [7:0] dat;
        logic [7:0] shOut;
        logic so;
        logic outEn;
        logic hold;
        logic wel;
        logic vwel;
        logic pd;
        logic busy;
        logic [`SPHS_TMR_W-1:0] tmr;
        logic [`SPHS_NUM_SR-1:0][7:0] sr;
        logic [`SPHS_NUM_SR-1:0][7:0] nv;
    } sphs_core_s;
endpackage
